// [logic/csl_pkg.sv]
`default_nettype none
package csl_pkg;
	// Register map, byte offsets on the register port
	localparam logic [7:0] REG_BC_CRC_ERR_A = 8'h0a;
	localparam logic [7:0] REG_BC_CRC_ERR_B = 8'h0b;
	localparam logic [7:0] REG_FWD_PAR_ERR_A = 8'h1a;
	localparam logic [7:0] REG_FWD_PAR_ERR_B = 8'h1b;
	localparam logic [7:0] REG_LINK_CTRL = 8'h20;
	localparam logic [7:0] REG_LINK_STAT = 8'h21;
	// Link control fields
	localparam int CTRL_SEL_BY_REG = 0;
	localparam int CTRL_SEL_VALUE = 1;
	localparam int CTRL_BC_DRV_EN = 2;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	// Forward frame layout
	localparam int FRAME_BITS = 28;
	localparam int FRM_PARITY = 27;
	localparam int FRM_CTRL = 26;
	localparam int FRM_BAL = 25;
	// Pixel word and payload widths per mode, sync bits included
	localparam logic [5:0] WORD_W_12 = 6'h0e;
	localparam logic [5:0] WORD_W_10 = 6'h0c;
	localparam logic [5:0] PAY_W_12LF = 6'h0e;
	localparam logic [5:0] PAY_W_10B = 6'h18;
	localparam logic [5:0] PAY_W_12HF = 6'h15;
	// Scrambler and back-channel check
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [15:0] LFSR_TAPS = 16'hb400;
	localparam logic [3:0] CRC4_POLY = 4'h3;
	localparam logic [3:0] CRC4_INIT = 4'h0;
	localparam logic [3:0] I2C_DATA_BITS = 4'h8;
	typedef enum logic [1:0] {CSL_MODE_12LF, CSL_MODE_10B, CSL_MODE_12HF, CSL_MODE_RSVD} csl_mode_t;
	typedef enum logic [1:0] {CSL_I2C_IDLE, CSL_I2C_BITS, CSL_I2C_HOLD, CSL_I2C_ACK} csl_i2c_st_t;
endpackage
`default_nettype wire

// [logic/csl_link_core.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_link_core (
	// Clock, reset, enable, lock
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic LOCK,
	input wire csl_pkg::csl_mode_t MODE,
	// Parallel pixel input
	input wire logic PIX_VALID,
	input wire logic [11:0] PIX_DATA,
	input wire logic HORIZONTAL_SYNC,
	input wire logic VERTICAL_SYNC,
	input wire logic CTRL_TX_BIT,
	// Forward frame out
	output logic FRAME_VALID,
	output logic [27:0] FRAME_DATA,
	// Forward frames in, two inputs
	input wire logic RXA_VALID,
	input wire logic [27:0] RXA_FRAME,
	input wire logic RXB_VALID,
	input wire logic [27:0] RXB_FRAME,
	input wire logic SEL_PIN,
	output logic BC_DRV_EN_A,
	output logic BC_DRV_EN_B,
	output logic PASS,
	// Recovered pixels
	output logic PIX_OUT_VALID,
	output logic [11:0] PIX_OUT_DATA,
	output logic HORIZONTAL_SYNC_OUT,
	output logic VERTICAL_SYNC_OUT,
	output logic CTRL_RX_BIT,
	// Back-channel words in
	input wire logic BC_VALID,
	input wire logic BC_KIND,
	input wire logic [7:0] BC_DATA,
	input wire logic [3:0] BC_CRC,
	output logic BC_OUT_VALID,
	output logic [7:0] BC_OUT_DATA,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// I2C target pins and remote forwarding
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	output logic FWD_BYTE_VALID,
	output logic [7:0] FWD_BYTE,
	input wire logic REMOTE_DONE,
	input wire logic REMOTE_ACK
);
	function automatic logic [47:0] low_mask(input logic [5:0] n);
		low_mask = ~(48'hffff_ffff_ffff << n);
	endfunction
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == csl_pkg::COUNT_MAX) ? v : v + 8'h01;
	endfunction
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		lfsr_step = s[0] ? ((s >> 1) ^ csl_pkg::LFSR_TAPS) : (s >> 1);
	endfunction
	function automatic logic ones_hi(input logic [24:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 25; i++) begin
			n = n + {4'h0, v[i]};
		end
		ones_hi = (n > 5'h0c);
	endfunction
	function automatic logic [3:0] crc4(input logic [7:0] d);
		logic [3:0] c;
		logic fb;
		c = csl_pkg::CRC4_INIT;
		for (int i = 7; i >= 0; i--) begin
			fb = c[3] ^ d[i];
			c = {c[2:0], 1'b0} ^ (fb ? csl_pkg::CRC4_POLY : 4'h0);
		end
		crc4 = c;
	endfunction

	logic [5:0] word_w, pay_w;
	logic mode10;
	always_comb begin
		mode10 = (MODE == csl_pkg::CSL_MODE_10B);
		case (MODE)
			csl_pkg::CSL_MODE_10B: begin
				word_w = csl_pkg::WORD_W_10;
				pay_w = csl_pkg::PAY_W_10B;
			end
			csl_pkg::CSL_MODE_12HF: begin
				word_w = csl_pkg::WORD_W_12;
				pay_w = csl_pkg::PAY_W_12HF;
			end
			default: begin
				word_w = csl_pkg::WORD_W_12;
				pay_w = csl_pkg::PAY_W_12LF;
			end
		endcase
	end

	// Transmit gearbox and framer
	logic [47:0] tx_acc_ff, nxt_tx_acc;
	logic [5:0] tx_cnt_ff, nxt_tx_cnt;
	logic [15:0] tx_lfsr_ff, nxt_tx_lfsr;
	logic tx_rd_ff, nxt_tx_rd, frm_vld_ff, nxt_frm_vld;
	logic [27:0] frm_ff, nxt_frm;
	always_comb begin
		logic [47:0] acc, word, msk;
		logic [5:0] cnt;
		logic [24:0] scr;
		logic [26:0] body;
		logic bal;
		acc = tx_acc_ff;
		cnt = tx_cnt_ff;
		word = 48'h0;
		msk = low_mask(pay_w);
		scr = 25'h0;
		body = 27'h0;
		bal = 1'b0;
		nxt_tx_lfsr = tx_lfsr_ff;
		nxt_tx_rd = tx_rd_ff;
		nxt_frm = frm_ff;
		nxt_frm_vld = 1'b0;
		if (PIX_VALID) begin
			if (mode10)
				word = {36'h0, VERTICAL_SYNC, HORIZONTAL_SYNC, PIX_DATA[9:0]};
			else
				word = {34'h0, VERTICAL_SYNC, HORIZONTAL_SYNC, PIX_DATA};
			acc = acc | (word << cnt);
			cnt = cnt + word_w;
		end
		if (cnt >= pay_w) begin
			scr = (acc[24:0] & msk[24:0]) ^ {tx_lfsr_ff[8:0], tx_lfsr_ff};
			bal = (ones_hi(scr) == tx_rd_ff);
			body = {CTRL_TX_BIT, bal, bal ? ~scr : scr};
			nxt_frm = {^body, body};
			nxt_frm_vld = 1'b1;
			nxt_tx_rd = ones_hi(body[24:0]);
			nxt_tx_lfsr = lfsr_step(tx_lfsr_ff);
			acc = acc >> pay_w;
			cnt = cnt - pay_w;
		end
		nxt_tx_acc = acc;
		nxt_tx_cnt = cnt;
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_acc_ff <= 48'h0;
			tx_cnt_ff <= 6'h00;
			tx_lfsr_ff <= csl_pkg::LFSR_SEED;
			tx_rd_ff <= 1'b0;
			frm_ff <= 28'h0;
			frm_vld_ff <= 1'b0;
		end else if (CE) begin
			tx_acc_ff <= nxt_tx_acc;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_lfsr_ff <= nxt_tx_lfsr;
			tx_rd_ff <= nxt_tx_rd;
			frm_ff <= nxt_frm;
			frm_vld_ff <= nxt_frm_vld;
		end
	end
	assign FRAME_VALID = frm_vld_ff;
	assign FRAME_DATA = frm_ff;

	// Control register, input select, back-channel drivers
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic drv_a_ff, drv_b_ff, nxt_drv_a, nxt_drv_b, sel_b;
	always_comb begin
		nxt_ctrl = (REG_WR && REG_ADDR == csl_pkg::REG_LINK_CTRL) ? REG_WDATA : ctrl_ff;
		sel_b = ctrl_ff[csl_pkg::CTRL_SEL_BY_REG] ? ctrl_ff[csl_pkg::CTRL_SEL_VALUE] : SEL_PIN;
		nxt_drv_a = !sel_b && ctrl_ff[csl_pkg::CTRL_BC_DRV_EN];
		nxt_drv_b = sel_b && ctrl_ff[csl_pkg::CTRL_BC_DRV_EN];
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff <= csl_pkg::CTRL_RESET;
			drv_a_ff <= 1'b0;
			drv_b_ff <= 1'b0;
		end else if (CE) begin
			ctrl_ff <= nxt_ctrl;
			drv_a_ff <= nxt_drv_a;
			drv_b_ff <= nxt_drv_b;
		end
	end
	assign BC_DRV_EN_A = drv_a_ff;
	assign BC_DRV_EN_B = drv_b_ff;

	// Receive checker and unpacker; unselected input is ignored
	logic [47:0] rx_acc_ff, nxt_rx_acc;
	logic [5:0] rx_cnt_ff, nxt_rx_cnt;
	logic [15:0] rx_lfsr_ff, nxt_rx_lfsr;
	logic [7:0] fwd_a_ff, fwd_b_ff, nxt_fwd_a, nxt_fwd_b;
	logic pass_ff, nxt_pass, pov_ff, nxt_pov, ctrl_rx_ff, nxt_ctrl_rx;
	logic [13:0] pout_ff, nxt_pout;
	always_comb begin
		logic [47:0] acc, msk;
		logic [5:0] cnt;
		logic [27:0] f;
		logic v;
		logic [24:0] raw;
		acc = rx_acc_ff;
		cnt = rx_cnt_ff;
		msk = low_mask(pay_w);
		f = sel_b ? RXB_FRAME : RXA_FRAME;
		v = sel_b ? RXB_VALID : RXA_VALID;
		raw = 25'h0;
		nxt_rx_lfsr = rx_lfsr_ff;
		nxt_fwd_a = fwd_a_ff;
		nxt_fwd_b = fwd_b_ff;
		nxt_pass = pass_ff;
		nxt_pov = 1'b0;
		nxt_pout = pout_ff;
		nxt_ctrl_rx = ctrl_rx_ff;
		if (cnt >= word_w) begin
			nxt_pov = 1'b1;
			nxt_pout = acc[13:0];
			acc = acc >> word_w;
			cnt = cnt - word_w;
		end
		if (v) begin
			if (^f) begin
				nxt_pass = 1'b0;
				if (sel_b)
					nxt_fwd_b = sat_inc(fwd_b_ff);
				else
					nxt_fwd_a = sat_inc(fwd_a_ff);
			end else begin
				nxt_pass = 1'b1;
			end
			raw = f[csl_pkg::FRM_BAL] ? ~f[24:0] : f[24:0];
			raw = raw ^ {rx_lfsr_ff[8:0], rx_lfsr_ff};
			acc = acc | (({23'h0, raw} & msk) << cnt);
			cnt = cnt + pay_w;
			nxt_rx_lfsr = lfsr_step(rx_lfsr_ff);
			nxt_ctrl_rx = f[csl_pkg::FRM_CTRL];
		end
		nxt_rx_acc = acc;
		nxt_rx_cnt = cnt;
		if (!LOCK) begin
			nxt_fwd_a = csl_pkg::COUNT_RESET;
			nxt_fwd_b = csl_pkg::COUNT_RESET;
			nxt_rx_lfsr = csl_pkg::LFSR_SEED;
			nxt_rx_acc = 48'h0;
			nxt_rx_cnt = 6'h00;
			nxt_pov = 1'b0;
		end
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_acc_ff <= 48'h0;
			rx_cnt_ff <= 6'h00;
			rx_lfsr_ff <= csl_pkg::LFSR_SEED;
			fwd_a_ff <= csl_pkg::COUNT_RESET;
			fwd_b_ff <= csl_pkg::COUNT_RESET;
			pass_ff <= 1'b1;
			pov_ff <= 1'b0;
			pout_ff <= 14'h0;
			ctrl_rx_ff <= 1'b0;
		end else if (CE) begin
			rx_acc_ff <= nxt_rx_acc;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_lfsr_ff <= nxt_rx_lfsr;
			fwd_a_ff <= nxt_fwd_a;
			fwd_b_ff <= nxt_fwd_b;
			pass_ff <= nxt_pass;
			pov_ff <= nxt_pov;
			pout_ff <= nxt_pout;
			ctrl_rx_ff <= nxt_ctrl_rx;
		end
	end
	assign PASS = pass_ff;
	assign PIX_OUT_VALID = pov_ff;
	assign CTRL_RX_BIT = ctrl_rx_ff;
	always_comb begin
		if (mode10) begin
			PIX_OUT_DATA = {2'h0, pout_ff[9:0]};
			HORIZONTAL_SYNC_OUT = pout_ff[10];
			VERTICAL_SYNC_OUT = pout_ff[11];
		end else begin
			PIX_OUT_DATA = pout_ff[11:0];
			HORIZONTAL_SYNC_OUT = pout_ff[12];
			VERTICAL_SYNC_OUT = pout_ff[13];
		end
	end

	// Back-channel CRC check and counters
	logic [7:0] bca_ff, bcb_ff, nxt_bca, nxt_bcb, bcd_ff, nxt_bcd;
	logic bcv_ff, nxt_bcv;
	always_comb begin
		nxt_bca = bca_ff;
		nxt_bcb = bcb_ff;
		nxt_bcv = 1'b0;
		nxt_bcd = bcd_ff;
		if (BC_VALID) begin
			if (crc4(BC_DATA) != BC_CRC) begin
				if (BC_KIND)
					nxt_bcb = sat_inc(bcb_ff);
				else
					nxt_bca = sat_inc(bca_ff);
			end else begin
				nxt_bcv = 1'b1;
				nxt_bcd = BC_DATA;
			end
		end
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bca_ff <= csl_pkg::COUNT_RESET;
			bcb_ff <= csl_pkg::COUNT_RESET;
			bcv_ff <= 1'b0;
			bcd_ff <= 8'h00;
		end else if (CE) begin
			bca_ff <= nxt_bca;
			bcb_ff <= nxt_bcb;
			bcv_ff <= nxt_bcv;
			bcd_ff <= nxt_bcd;
		end
	end
	assign BC_OUT_VALID = bcv_ff;
	assign BC_OUT_DATA = bcd_ff;

	// Register read-back, one cycle behind the address
	logic [7:0] rd_ff, nxt_rd;
	always_comb begin
		case (REG_ADDR)
			csl_pkg::REG_BC_CRC_ERR_A: nxt_rd = bca_ff;
			csl_pkg::REG_BC_CRC_ERR_B: nxt_rd = bcb_ff;
			csl_pkg::REG_FWD_PAR_ERR_A: nxt_rd = fwd_a_ff;
			csl_pkg::REG_FWD_PAR_ERR_B: nxt_rd = fwd_b_ff;
			csl_pkg::REG_LINK_CTRL: nxt_rd = ctrl_ff;
			csl_pkg::REG_LINK_STAT: nxt_rd = {5'h00, pass_ff, sel_b, LOCK};
			default: nxt_rd = 8'h00;
		endcase
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			rd_ff <= 8'h00;
		else if (CE)
			rd_ff <= nxt_rd;
	end
	assign REG_RDATA = rd_ff;

	// I2C byte tracker with ninth-clock stretch; lines sampled at 250 MHz
	csl_pkg::csl_i2c_st_t st_ff, nxt_st;
	logic scl_q_ff, sda_q_ff, scl_hold_ff, sda_hold_ff, nxt_scl_hold, nxt_sda_hold;
	logic ack_ff, nxt_ack, fbv_ff, nxt_fbv;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] sh_ff, nxt_sh, fb_ff, nxt_fb;
	always_comb begin
		logic start, stop, rise, fall;
		start = sda_q_ff && !SDA_IN && SCL_IN && scl_q_ff;
		stop = !sda_q_ff && SDA_IN && SCL_IN && scl_q_ff;
		rise = !scl_q_ff && SCL_IN;
		fall = scl_q_ff && !SCL_IN;
		nxt_st = st_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_fb = fb_ff;
		nxt_fbv = 1'b0;
		nxt_ack = ack_ff;
		case (st_ff)
			csl_pkg::CSL_I2C_IDLE: begin
				if (start) begin
					nxt_st = csl_pkg::CSL_I2C_BITS;
					nxt_bit = 4'h0;
				end
			end
			csl_pkg::CSL_I2C_BITS: begin
				if (rise) begin
					nxt_sh = {sh_ff[6:0], SDA_IN};
					nxt_bit = bit_ff + 4'h1;
				end
				if (fall && bit_ff == csl_pkg::I2C_DATA_BITS) begin
					nxt_st = csl_pkg::CSL_I2C_HOLD;
					nxt_fb = sh_ff;
					nxt_fbv = 1'b1;
				end
				if (start)
					nxt_bit = 4'h0;
				if (stop)
					nxt_st = csl_pkg::CSL_I2C_IDLE;
			end
			csl_pkg::CSL_I2C_HOLD: begin
				if (REMOTE_DONE) begin
					nxt_st = csl_pkg::CSL_I2C_ACK;
					nxt_ack = REMOTE_ACK;
				end
			end
			csl_pkg::CSL_I2C_ACK: begin
				if (fall) begin
					nxt_st = csl_pkg::CSL_I2C_BITS;
					nxt_bit = 4'h0;
					nxt_ack = 1'b0;
				end
			end
			default: nxt_st = csl_pkg::CSL_I2C_IDLE;
		endcase
		nxt_scl_hold = (nxt_st == csl_pkg::CSL_I2C_HOLD);
		nxt_sda_hold = (nxt_st == csl_pkg::CSL_I2C_ACK) && nxt_ack;
	end
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_ff <= csl_pkg::CSL_I2C_IDLE;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			scl_hold_ff <= 1'b0;
			sda_hold_ff <= 1'b0;
			ack_ff <= 1'b0;
			fbv_ff <= 1'b0;
			bit_ff <= 4'h0;
			sh_ff <= 8'h00;
			fb_ff <= 8'h00;
		end else if (CE) begin
			st_ff <= nxt_st;
			scl_q_ff <= SCL_IN;
			sda_q_ff <= SDA_IN;
			scl_hold_ff <= nxt_scl_hold;
			sda_hold_ff <= nxt_sda_hold;
			ack_ff <= nxt_ack;
			fbv_ff <= nxt_fbv;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			fb_ff <= nxt_fb;
		end
	end
	// Open drain: only ever pull low, enable is active low
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE_N = !scl_hold_ff;
	assign SDA_OE_N = !sda_hold_ff;
	assign FWD_BYTE_VALID = fbv_ff;
	assign FWD_BYTE = fb_ff;
endmodule
`default_nettype wire

// [verification/csl_link_core_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_chk (
	// Clock, reset, mode
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic LOCK,
	input wire csl_pkg::csl_mode_t MODE,
	// Framer
	input wire logic PIX_VALID,
	input wire logic CTRL_TX_BIT,
	input wire logic FRAME_VALID,
	input wire logic [27:0] FRAME_DATA,
	// Receiver
	input wire logic RXA_VALID,
	input wire logic [27:0] RXA_FRAME,
	input wire logic BC_DRV_EN_A,
	input wire logic BC_DRV_EN_B,
	input wire logic PASS,
	// Back channel
	input wire logic BC_VALID,
	input wire logic [7:0] BC_DATA,
	input wire logic BC_OUT_VALID,
	input wire logic [7:0] BC_OUT_DATA,
	// I2C
	input wire logic SCL_OUT,
	input wire logic SCL_OE_N,
	input wire logic SDA_OUT,
	input wire logic FWD_BYTE_VALID,
	input wire logic REMOTE_DONE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	chk_drv_one: assert property (!(BC_DRV_EN_A && BC_DRV_EN_B))
		else $error("both back-channel drivers on");
	chk_frm_par: assert property (FRAME_VALID |-> ^FRAME_DATA == 1'b0)
		else $error("frame parity odd");
	chk_frm_rate: assert property (CE && PIX_VALID && MODE == csl_pkg::CSL_MODE_12LF
		|=> FRAME_VALID && FRAME_DATA[csl_pkg::FRM_CTRL] == $past(CTRL_TX_BIT))
		else $error("no frame for pixel");
	// A's driver being on tells that input A was the selected one a cycle earlier
	chk_pass_low: assert property (CE && LOCK && RXA_VALID && BC_DRV_EN_A && ^RXA_FRAME
		|=> !PASS)
		else $error("pass high after parity error");
	chk_od_lines: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
		else $error("i2c line driven high");
	chk_hold_ninth: assert property (FWD_BYTE_VALID |-> $fell(SCL_OE_N))
		else $error("scl not held on ninth clock");
	chk_hold_wait: assert property (CE && !SCL_OE_N && !REMOTE_DONE |=> !SCL_OE_N)
		else $error("scl released early");
	chk_hold_end: assert property (CE && !SCL_OE_N && REMOTE_DONE |=> SCL_OE_N)
		else $error("scl not released");
	chk_bc_word: assert property (BC_OUT_VALID |-> $past(BC_VALID)
		&& BC_OUT_DATA == $past(BC_DATA))
		else $error("back-channel word wrong");
	cover property (FWD_BYTE_VALID);
	cover property (CE && REMOTE_DONE && !SCL_OE_N);
	cover property ($fell(PASS));
endmodule
bind csl_link_core csl_chk u_chk (.REF_CLK, .RSTN, .CE, .LOCK, .MODE, .PIX_VALID,
	.CTRL_TX_BIT, .FRAME_VALID, .FRAME_DATA, .RXA_VALID, .RXA_FRAME, .BC_DRV_EN_A,
	.BC_DRV_EN_B, .PASS, .BC_VALID, .BC_DATA, .BC_OUT_VALID, .BC_OUT_DATA, .SCL_OUT,
	.SCL_OE_N, .SDA_OUT, .FWD_BYTE_VALID, .REMOTE_DONE);
`default_nettype wire

// [verification/csl_i2c_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_i2c_peer (
	// Clock and wire levels
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	// Master pulls, high means released
	output logic scl_m = 1'b1,
	output logic sda_m = 1'b1,
	// Remote peripheral
	input wire logic fwd_valid,
	output logic done = 1'b0,
	output logic ack = 1'b0
);
	localparam int H = 10;
	int dly = 1;
	logic ack_val = 1'b1;
	// Ack toggles outside answers so a stale level never looks valid
	always @(negedge clk) begin
		done <= 1'b0;
		ack <= ~ack;
		if (fwd_valid) begin
			repeat (dly) @(negedge clk);
			done <= 1'b1;
			ack <= ack_val;
		end
	end
	task automatic rise(output logic to);
		scl_m = 1'b1;
		to = 1'b1;
		for (int k = 0; k < 400; k++) begin
			@(negedge clk);
			if (scl) begin
				to = 1'b0;
				break;
			end
		end
	endtask
	task automatic xfer(input logic [7:0] b, input int d, input logic a,
		output logic got, output logic to);
		logic t;
		dly = d;
		ack_val = a;
		to = 1'b0;
		sda_m = 1'b0;
		repeat (H) @(negedge clk);
		scl_m = 1'b0;
		for (int i = 7; i >= -1; i--) begin
			sda_m = (i < 0) ? 1'b1 : b[i];
			repeat (H) @(negedge clk);
			rise(t);
			to |= t;
			got = ~sda;
			repeat (H) @(negedge clk);
			scl_m = 1'b0;
		end
		sda_m = 1'b0;
		repeat (H) @(negedge clk);
		scl_m = 1'b1;
		repeat (H) @(negedge clk);
		sda_m = 1'b1;
		repeat (H) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic RSTN = 1'b0, CE = 1'b1, LOCK = 1'b1, PIX_VALID = 1'b0, CTRL_TX_BIT = 1'b0;
	logic HORIZONTAL_SYNC = 1'b0, VERTICAL_SYNC = 1'b0, SEL_PIN = 1'b0, REG_WR = 1'b0;
	logic BC_VALID = 1'b0, BC_KIND = 1'b0, REF_CLK, bad, got_ack, to, bc_seen, ctl;
	logic [11:0] PIX_DATA = 12'h000, msk = 12'hfff;
	logic [7:0] BC_DATA = 8'h00, REG_ADDR = 8'h00, REG_WDATA = 8'h00;
	logic [3:0] BC_CRC = 4'h0;
	logic [27:0] flip_a = 28'h0, flip_b = 28'h0, FRAME_DATA, RXA_FRAME, RXB_FRAME;
	csl_pkg::csl_mode_t MODE = csl_pkg::CSL_MODE_12LF;
	logic FRAME_VALID, BC_DRV_EN_A, BC_DRV_EN_B, PASS, PIX_OUT_VALID, HORIZONTAL_SYNC_OUT;
	logic VERTICAL_SYNC_OUT, CTRL_RX_BIT, BC_OUT_VALID, SCL_OUT, SCL_OE_N, SDA_OUT;
	logic SDA_OE_N, FWD_BYTE_VALID, REMOTE_DONE, REMOTE_ACK, scl_m, sda_m;
	logic [11:0] PIX_OUT_DATA;
	logic [7:0] BC_OUT_DATA, REG_RDATA, FWD_BYTE, bc_got, fb, v8;
	logic [13:0] w, exp_pix[$];
	logic [7:0] ra[7] = '{8'h0a, 8'h0b, 8'h1a, 8'h1b, 8'h20, 8'h21, 8'h30};
	logic [7:0] cv[4] = '{8'h04, 8'h05, 8'h03, 8'h07};
	logic [1:0] dv[4] = '{2'b01, 2'b10, 2'b00, 2'b01};
	int num_errors, compares, nfr, pc, bc[2], fp[2], nexp[4] = '{6, 3, 4, 6};
	// Payload bits per frame by mode, reserved mode runs as 12-bit LF
	int pw[4] = '{csl_pkg::PAY_W_12LF, csl_pkg::PAY_W_10B, csl_pkg::PAY_W_12HF, csl_pkg::PAY_W_12LF};
	wire logic scl_w = (SCL_OE_N | SCL_OUT) & scl_m;
	wire logic sda_w = (SDA_OE_N | SDA_OUT) & sda_m;
	assign RXA_FRAME = FRAME_DATA ^ flip_a;
	assign RXB_FRAME = FRAME_DATA ^ flip_b;
	csl_link_core u_dut (.REF_CLK, .RSTN, .CE, .LOCK, .MODE, .PIX_VALID, .PIX_DATA,
		.HORIZONTAL_SYNC, .VERTICAL_SYNC, .CTRL_TX_BIT, .FRAME_VALID, .FRAME_DATA,
		.RXA_VALID(FRAME_VALID), .RXA_FRAME, .RXB_VALID(FRAME_VALID), .RXB_FRAME, .SEL_PIN,
		.BC_DRV_EN_A, .BC_DRV_EN_B, .PASS, .PIX_OUT_VALID, .PIX_OUT_DATA,
		.HORIZONTAL_SYNC_OUT, .VERTICAL_SYNC_OUT, .CTRL_RX_BIT, .BC_VALID, .BC_KIND,
		.BC_DATA, .BC_CRC, .BC_OUT_VALID, .BC_OUT_DATA, .REG_ADDR, .REG_WR, .REG_WDATA,
		.REG_RDATA, .SCL_IN(scl_w), .SCL_OUT, .SCL_OE_N, .SDA_IN(sda_w), .SDA_OUT,
		.SDA_OE_N, .FWD_BYTE_VALID, .FWD_BYTE, .REMOTE_DONE, .REMOTE_ACK);
	csl_i2c_peer u_peer (.clk(REF_CLK), .scl(scl_w), .sda(sda_w), .scl_m, .sda_m,
		.fwd_valid(FWD_BYTE_VALID), .done(REMOTE_DONE), .ack(REMOTE_ACK));
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input string s, input logic [27:0] e, input logic [27:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input int e);
		REG_ADDR = a;
		repeat (2) @(negedge REF_CLK);
		cmp($sformatf("reg %h", a), 28'(e), 28'(REG_RDATA));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge REF_CLK);
		REG_WR = 1'b0;
	endtask
	task automatic pix(input int n);
		logic [13:0] v;
		repeat (n) begin
			v = 14'($urandom);
			{VERTICAL_SYNC, HORIZONTAL_SYNC, PIX_DATA} = v;
			CTRL_TX_BIT = 1'($urandom);
			PIX_VALID = 1'b1;
			exp_pix.push_back(v & {2'b11, msk});
			pc += (MODE == csl_pkg::CSL_MODE_10B) ? 12 : 14;
			if (pc >= pw[MODE]) begin
				pc -= pw[MODE];
				ctl = CTRL_TX_BIT;
			end
			@(negedge REF_CLK);
			PIX_VALID = 1'b0;
			repeat (3) @(negedge REF_CLK);
			cmp("ctrl bit", 28'(ctl), 28'(CTRL_RX_BIT));
		end
		repeat (10) @(negedge REF_CLK);
	endtask
	function automatic logic [3:0] crc4(input logic [7:0] d);
		logic [3:0] c;
		c = csl_pkg::CRC4_INIT;
		for (int i = 7; i >= 0; i--)
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? csl_pkg::CRC4_POLY : 4'h0);
		return c;
	endfunction
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	initial begin
		repeat (100000) @(posedge REF_CLK);
		num_errors++;
		wrap_up();
	end
	always @(negedge REF_CLK) begin
		if (FRAME_VALID)
			nfr++;
		if (BC_OUT_VALID) begin
			bc_seen = 1'b1;
			bc_got = BC_OUT_DATA;
		end
		if (FWD_BYTE_VALID)
			fb = FWD_BYTE;
		if (PIX_OUT_VALID) begin
			w = exp_pix.pop_front();
			cmp("pixel", 28'(w), 28'({VERTICAL_SYNC_OUT, HORIZONTAL_SYNC_OUT, PIX_OUT_DATA & msk}));
		end
	end
	initial begin
		void'($urandom(32'h7a723d98));
		repeat (12) @(negedge REF_CLK);
		RSTN = 1'b1;
		@(negedge REF_CLK);
		foreach (ra[i])
			rd(ra[i], (i == 4) ? csl_pkg::CTRL_RESET : ((i == 5) ? 8'h05 : 8'h00));
		$display("test regs done");
		for (int m = 0; m < 4; m++) begin
			MODE = csl_pkg::csl_mode_t'(m);
			msk = (m == 1) ? 12'h3ff : 12'hfff;
			nfr = 0;
			pix(6);
			cmp("frames", 28'(nexp[m]), 28'(nfr));
			cmp("pix left", 28'h0, 28'(exp_pix.size()));
		end
		$display("test modes done");
		MODE = csl_pkg::CSL_MODE_12LF;
		msk = 12'hfff;
		flip_a = 28'h8000000;
		pix(2);
		fp[0] += 2;
		cmp("pass", 28'h0, 28'(PASS));
		flip_a = 28'h0;
		pix(1);
		cmp("pass", 28'h1, 28'(PASS));
		rd(csl_pkg::REG_FWD_PAR_ERR_A, fp[0]);
		SEL_PIN = 1'b1;
		foreach (cv[i]) begin
			wr(csl_pkg::REG_LINK_CTRL, cv[i]);
			@(negedge REF_CLK);
			cmp("drivers", 28'(dv[i]), 28'({BC_DRV_EN_A, BC_DRV_EN_B}));
			rd(csl_pkg::REG_LINK_CTRL, cv[i]);
		end
		flip_a = 28'h8000000;
		flip_b = 28'h8000000;
		pix(3);
		fp[1] += 3;
		rd(csl_pkg::REG_FWD_PAR_ERR_A, fp[0]);
		rd(csl_pkg::REG_FWD_PAR_ERR_B, fp[1]);
		$display("test select done");
		for (int i = 0; i < 600; i++) begin
			BC_KIND = i[0];
			BC_DATA = 8'($urandom);
			bad = !BC_KIND || $urandom_range(3) == 0;
			BC_CRC = crc4(BC_DATA) ^ {3'b000, bad};
			BC_VALID = 1'b1;
			bc_seen = 1'b0;
			@(negedge REF_CLK);
			BC_VALID = 1'b0;
			if (bad && bc[i % 2] < 255)
				bc[i % 2]++;
			repeat (3) @(negedge REF_CLK);
			cmp("bc word", 28'({!bad, bad ? 8'h00 : BC_DATA}), 28'({bc_seen, bad ? 8'h00 : bc_got}));
		end
		rd(csl_pkg::REG_BC_CRC_ERR_A, bc[0]);
		rd(csl_pkg::REG_BC_CRC_ERR_B, bc[1]);
		// A bad word offered while frozen must not count
		CE = 1'b0;
		BC_KIND = 1'b1;
		BC_DATA = 8'h5a;
		BC_CRC = ~crc4(8'h5a);
		BC_VALID = 1'b1;
		@(negedge REF_CLK);
		BC_VALID = 1'b0;
		CE = 1'b1;
		rd(csl_pkg::REG_BC_CRC_ERR_B, bc[1]);
		$display("test back channel done");
		for (int i = 0; i < 2; i++) begin
			v8 = 8'($urandom);
			u_peer.xfer(v8, (i == 0) ? 1 : 40, i == 0, got_ack, to);
			if (to) begin
				num_errors++;
				wrap_up();
			end
			cmp("fwd byte", 28'(v8), 28'(fb));
			cmp("ack", 28'(i == 0), 28'(got_ack));
		end
		$display("test i2c done");
		LOCK = 1'b0;
		repeat (2) @(negedge REF_CLK);
		rd(csl_pkg::REG_FWD_PAR_ERR_A, 0);
		rd(csl_pkg::REG_FWD_PAR_ERR_B, 0);
		rd(csl_pkg::REG_LINK_STAT, 8'h02);
		$display("test lock done");
		wrap_up();
	end
endmodule
`default_nettype wire
